// File: design/fs2_fault_status.sv
// fs2_fault_status: fault status register two with its register port
`timescale 1ns/1ps
`default_nettype none
module fs2_fault_status #(
  parameter int unsigned AN_CHANNELS = fs2_pkg::FS2_AN_CHANNELS,
  parameter int unsigned PIN_CHANNELS = fs2_pkg::FS2_PIN_CHANNELS,
  parameter int unsigned BAL_SWITCHES = fs2_pkg::FS2_BAL_SWITCHES
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire fs2_pkg::fs2_reg_req_t i_reg_req,
  output logic [fs2_pkg::FS2_DATA_W-1:0] o_reg_rdata,
  output logic o_reg_ack,
  input wire fs2_pkg::fs2_events_t i_events,
  input wire fs2_pkg::fs2_detail_t i_details,
  input wire logic [fs2_pkg::FS2_DATA_W-1:0] i_init_flip,
  input wire fs2_pkg::fs2_reset_cause_t i_reset_cause,
  output logic [fs2_pkg::FS2_DATA_W-1:0] o_status,
  output logic [fs2_pkg::FS2_DATA_W-1:0] o_new_flags
);

  // or-reduction of a detail vector
  function automatic logic any_set(input logic [31:0] vec);
    any_set = |vec;
  endfunction

  // address match for this register
  function automatic logic addr_hit(input logic [fs2_pkg::FS2_ADDR_W-1:0] addr);
    addr_hit = (addr == fs2_pkg::FS2_STATUS_ADDR);
  endfunction

  // sequencer state
  fs2_pkg::fs2_state_t state_reg;
  fs2_pkg::fs2_state_t state_next;
  logic load_now;

  always_comb begin
    state_next = state_reg;
    load_now = 1'b0;
    unique case (state_reg)
      fs2_pkg::FS2_ST_CAPTURE: begin
        load_now = 1'b1;
        state_next = fs2_pkg::FS2_ST_RUN;
      end
      fs2_pkg::FS2_ST_RUN: begin
        state_next = fs2_pkg::FS2_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= fs2_pkg::FS2_ST_CAPTURE;
    end else begin
      state_reg <= state_next;
    end
  end

  // values loaded once after reset release
  logic [fs2_pkg::FS2_DATA_W-1:0] load_val;

  always_comb begin
    load_val = i_init_flip & fs2_pkg::FS2_INIT_FLIP_MASK;
    load_val[fs2_pkg::FS2_BIT_OSC] = load_val[fs2_pkg::FS2_BIT_OSC]
      | i_reset_cause.osc_fault;
    load_val[fs2_pkg::FS2_BIT_FUSE_LOAD] = i_reset_cause.fuse_abort;
  end

  // hardware set requests
  logic [fs2_pkg::FS2_DATA_W-1:0] set_vec;

  always_comb begin
    set_vec = fs2_pkg::FS2_RESET;
    set_vec[fs2_pkg::FS2_BIT_COM_OV] = i_events.common_supply_over;
    set_vec[fs2_pkg::FS2_BIT_COM_UV] = i_events.common_supply_under;
    set_vec[fs2_pkg::FS2_BIT_ANA_OV] = i_events.analog_supply_over;
    set_vec[fs2_pkg::FS2_BIT_ANA_UV] = i_events.analog_supply_under;
    set_vec[fs2_pkg::FS2_BIT_CONV_B] = i_events.converter_b_ref;
    set_vec[fs2_pkg::FS2_BIT_CONV_A] = i_events.converter_a_ref;
    set_vec[fs2_pkg::FS2_BIT_GND] = i_events.ground_loss;
    set_vec[fs2_pkg::FS2_BIT_THERM] = i_events.thermal_limit;
    set_vec[fs2_pkg::FS2_BIT_IDLE] = i_events.idle_pass;
    set_vec[fs2_pkg::FS2_BIT_OSC] = i_events.low_power_osc;
    set_vec[fs2_pkg::FS2_BIT_FUSE_DED] = i_events.fuse_double_error;
    set_vec[fs2_pkg::FS2_BIT_FUSE_LOAD] = i_events.fuse_load;
  end

  // summary levels from the detail registers
  logic [fs2_pkg::FS2_DATA_W-1:0] level_vec;

  always_comb begin
    level_vec = fs2_pkg::FS2_RESET;
    level_vec[fs2_pkg::FS2_BIT_AN_OPEN] =
      any_set(32'(i_details.analog_open));
    level_vec[fs2_pkg::FS2_BIT_PIN_SHORT] =
      any_set(32'(i_details.pin_short));
    level_vec[fs2_pkg::FS2_BIT_BAL_SHORT] =
      any_set(32'(i_details.bal_short));
    level_vec[fs2_pkg::FS2_BIT_BAL_OPEN] =
      any_set(32'(i_details.bal_open));
  end

  // host read and write decode
  logic wr_hit;
  logic rd_hit;
  logic [fs2_pkg::FS2_DATA_W-1:0] clear_vec;

  always_comb begin
    wr_hit = i_reg_req.sel & i_reg_req.wr & addr_hit(i_reg_req.addr);
    rd_hit = i_reg_req.sel & ~i_reg_req.wr & addr_hit(i_reg_req.addr);
    clear_vec = fs2_pkg::FS2_RESET;
    if (wr_hit) begin
      clear_vec = ~i_reg_req.wdata & fs2_pkg::FS2_W0C_MASK;
    end
  end

  // flag storage
  logic [fs2_pkg::FS2_DATA_W-1:0] flags;

  fs2_flag_bank #(
    .WIDTH(fs2_pkg::FS2_DATA_W),
    .W0C_MASK(fs2_pkg::FS2_W0C_MASK),
    .LEVEL_MASK(fs2_pkg::FS2_SUMMARY_MASK)
  ) u_bank (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_load(load_now),
    .i_load_val(load_val),
    .i_set(set_vec),
    .i_clear(clear_vec),
    .i_level(level_vec),
    .o_flags(flags)
  );

  // read port and status outputs
  logic [fs2_pkg::FS2_DATA_W-1:0] rdata_reg;
  logic [fs2_pkg::FS2_DATA_W-1:0] rdata_next;
  logic ack_reg;
  logic ack_next;
  logic [fs2_pkg::FS2_DATA_W-1:0] prev_flags_reg;
  logic [fs2_pkg::FS2_DATA_W-1:0] new_reg;
  logic [fs2_pkg::FS2_DATA_W-1:0] new_next;

  always_comb begin
    rdata_next = fs2_pkg::FS2_RESET;
    if (rd_hit) begin
      rdata_next = flags;
    end
    ack_next = wr_hit | rd_hit;
    new_next = flags & ~prev_flags_reg;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_reg <= fs2_pkg::FS2_RESET;
      ack_reg <= 1'b0;
      prev_flags_reg <= fs2_pkg::FS2_RESET;
      new_reg <= fs2_pkg::FS2_RESET;
    end else begin
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
      prev_flags_reg <= flags;
      new_reg <= new_next;
    end
  end

  assign o_reg_rdata = rdata_reg;
  assign o_reg_ack = ack_reg;
  assign o_status = flags;
  assign o_new_flags = new_reg;

endmodule // fs2_fault_status
`default_nettype wire

// File: common/fs2_pkg.sv
// fs2_pkg: constants, carriers and states for fault status register two
package fs2_pkg;

  localparam int unsigned FS2_ADDR_W = 7;
  localparam int unsigned FS2_DATA_W = 16;
  localparam logic [FS2_ADDR_W-1:0] FS2_STATUS_ADDR = 7'h25;

  localparam int unsigned FS2_BIT_COM_OV = 15;
  localparam int unsigned FS2_BIT_COM_UV = 14;
  localparam int unsigned FS2_BIT_ANA_OV = 13;
  localparam int unsigned FS2_BIT_ANA_UV = 12;
  localparam int unsigned FS2_BIT_CONV_B = 11;
  localparam int unsigned FS2_BIT_CONV_A = 10;
  localparam int unsigned FS2_BIT_GND = 9;
  localparam int unsigned FS2_BIT_THERM = 8;
  localparam int unsigned FS2_BIT_IDLE = 7;
  localparam int unsigned FS2_BIT_AN_OPEN = 6;
  localparam int unsigned FS2_BIT_PIN_SHORT = 5;
  localparam int unsigned FS2_BIT_BAL_SHORT = 4;
  localparam int unsigned FS2_BIT_BAL_OPEN = 3;
  localparam int unsigned FS2_BIT_OSC = 2;
  localparam int unsigned FS2_BIT_FUSE_DED = 1;
  localparam int unsigned FS2_BIT_FUSE_LOAD = 0;

  localparam logic [FS2_DATA_W-1:0] FS2_RESET = 16'h0000;
  localparam logic [FS2_DATA_W-1:0] FS2_W0C_MASK = 16'hFF87;
  localparam logic [FS2_DATA_W-1:0] FS2_SUMMARY_MASK = 16'h0078;
  localparam logic [FS2_DATA_W-1:0] FS2_INIT_FLIP_MASK = 16'hF206;

  localparam int unsigned FS2_AN_CHANNELS = 7;
  localparam int unsigned FS2_PIN_CHANNELS = 7;
  localparam int unsigned FS2_BAL_SWITCHES = 14;

  typedef struct packed {
    logic common_supply_over;
    logic common_supply_under;
    logic analog_supply_over;
    logic analog_supply_under;
    logic converter_b_ref;
    logic converter_a_ref;
    logic ground_loss;
    logic thermal_limit;
    logic idle_pass;
    logic low_power_osc;
    logic fuse_double_error;
    logic fuse_load;
  } fs2_events_t;

  typedef struct packed {
    logic [FS2_AN_CHANNELS-1:0] analog_open;
    logic [FS2_PIN_CHANNELS-1:0] pin_short;
    logic [FS2_BAL_SWITCHES-1:0] bal_short;
    logic [FS2_BAL_SWITCHES-1:0] bal_open;
  } fs2_detail_t;

  typedef struct packed {
    logic osc_fault;
    logic fuse_abort;
  } fs2_reset_cause_t;

  typedef struct packed {
    logic sel;
    logic wr;
    logic [FS2_ADDR_W-1:0] addr;
    logic [FS2_DATA_W-1:0] wdata;
  } fs2_reg_req_t;

  typedef enum logic [0:0] {
    FS2_ST_CAPTURE,
    FS2_ST_RUN
  } fs2_state_t;

endpackage

// File: design/fs2_flag_bank.sv
// fs2_flag_bank: sticky write-zero-clear flags with level-follow positions
`timescale 1ns/1ps
`default_nettype none
module fs2_flag_bank #(
  parameter int unsigned WIDTH = 16,
  parameter logic [WIDTH-1:0] W0C_MASK = '1,
  parameter logic [WIDTH-1:0] LEVEL_MASK = '0
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_load_val,
  input wire logic [WIDTH-1:0] i_set,
  input wire logic [WIDTH-1:0] i_clear,
  input wire logic [WIDTH-1:0] i_level,
  output logic [WIDTH-1:0] o_flags
);

  logic [WIDTH-1:0] flags_reg;
  logic [WIDTH-1:0] flags_next;

  always_comb begin
    flags_next = flags_reg & ~(i_clear & W0C_MASK);
    if (i_load) begin
      flags_next = flags_next | i_load_val;
    end
    flags_next = (flags_next | i_set) & W0C_MASK;
    flags_next = flags_next | (i_level & LEVEL_MASK);
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign o_flags = flags_reg;

endmodule // fs2_flag_bank
`default_nettype wire

// File: tb/fs2_fault_status_chk.sv
// fs2_fault_status_chk: port assertions for fault status register two
`timescale 1ns/1ps
`default_nettype none
module fs2_fault_status_chk #(
  parameter int unsigned AN_CHANNELS = 7,
  parameter int unsigned PIN_CHANNELS = 7,
  parameter int unsigned BAL_SWITCHES = 14
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire fs2_pkg::fs2_reg_req_t i_reg_req,
  input wire logic [15:0] o_reg_rdata,
  input wire logic o_reg_ack,
  input wire fs2_pkg::fs2_events_t i_events,
  input wire fs2_pkg::fs2_detail_t i_details,
  input wire logic [15:0] i_init_flip,
  input wire fs2_pkg::fs2_reset_cause_t i_reset_cause,
  input wire logic [15:0] o_status,
  input wire logic [15:0] o_new_flags
);
  localparam logic [15:0] WM = fs2_pkg::FS2_W0C_MASK;
  wire logic hit = i_reg_req.sel && i_reg_req.addr == fs2_pkg::FS2_STATUS_ADDR;
  wire logic [15:0] wz = (hit && i_reg_req.wr) ? ~i_reg_req.wdata : 16'h0000;
  wire logic [15:0] ev = {i_events[11:3], 4'h0, i_events[2:0]};
  wire logic [3:0] sm = {|i_details.analog_open, |i_details.pin_short,
    |i_details.bal_short, |i_details.bal_open};
  logic [1:0] run_reg;
  logic [1:0] run_next;
  always_comb run_next = {run_reg[0], 1'b1};
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) run_reg <= 2'b00;
    else run_reg <= run_next;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_rel; $rose(i_rstn); endsequence
  sequence s_rd; hit && !i_reg_req.wr; endsequence
  AST_INIT: assert property (s_rel |=> (~o_status & (($past(i_init_flip) & 16'hF206) |
    {13'h0, $past(i_reset_cause[1]), 1'b0, $past(i_reset_cause[0])})) == 16'h0)
    else $error("init load missing");
  AST_ACK: assert property (run_reg[0] |-> o_reg_ack == $past(hit))
    else $error("ack mismatch");
  AST_RD: assert property (s_rd |=> o_reg_rdata == $past(o_status))
    else $error("read data mismatch");
  AST_SET: assert property ((|ev) |=> (o_status & $past(ev)) == $past(ev))
    else $error("event not latched");
  AST_W0C: assert property (run_reg[0] && (|wz) |=> (o_status & WM & $past(wz) & ~$past(ev)) == 0)
    else $error("write zero did not clear");
  AST_RISE: assert property (run_reg[1] |-> (o_status & ~$past(o_status) & WM & ~$past(ev)) == 0)
    else $error("flag rose without event");
  AST_HOLD: assert property (($past(o_status) & ~o_status & WM & ~$past(wz)) == 16'h0)
    else $error("flag fell without clear");
  AST_SUM: assert property (run_reg[0] |-> o_status[6:3] == $past(sm))
    else $error("summary mismatch");
  AST_NEW: assert property (run_reg[1] |-> o_new_flags == ($past(o_status) & ~$past(o_status, 2)))
    else $error("new flag pulse mismatch");
endmodule // fs2_fault_status_chk
bind fs2_fault_status fs2_fault_status_chk #(.AN_CHANNELS(AN_CHANNELS),
  .PIN_CHANNELS(PIN_CHANNELS), .BAL_SWITCHES(BAL_SWITCHES)) u_chk (.i_clk(i_clk),
  .i_rstn(i_rstn), .i_reg_req(i_reg_req), .o_reg_rdata(o_reg_rdata), .o_reg_ack(o_reg_ack),
  .i_events(i_events), .i_details(i_details), .i_init_flip(i_init_flip),
  .i_reset_cause(i_reset_cause), .o_status(o_status), .o_new_flags(o_new_flags));
`default_nettype wire

// File: tb/fs2_fault_status_tb.sv
// fs2_fault_status_tb: directed tests for fault status register two
`timescale 1ns/1ps
`default_nettype none
module fs2_fault_status_tb;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  fs2_pkg::fs2_reg_req_t req = '0;
  fs2_pkg::fs2_events_t ev = '0;
  fs2_pkg::fs2_detail_t det = '0;
  fs2_pkg::fs2_reset_cause_t cause = '0;
  logic [15:0] flip = 16'h0000;
  logic [15:0] rdata, status, rd, nf;
  logic ack, ak;
  int err_count = 0;
  int samples_checked = 0;
  int pos [12] = '{15, 14, 13, 12, 11, 10, 9, 8, 7, 2, 1, 0};
  int dpos [4] = '{41, 34, 27, 13};
  always #50 i_clk = ~i_clk;
  fs2_fault_status uut (.i_clk(i_clk), .i_rstn(i_rstn), .i_reg_req(req), .o_reg_rdata(rdata),
    .o_reg_ack(ack), .i_events(ev), .i_details(det), .i_init_flip(flip),
    .i_reset_cause(cause), .o_status(status), .o_new_flags(nf));
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic acc(input logic w, input logic [6:0] a, input logic [15:0] d);
    @(posedge i_clk);
    req <= '{1'b1, w, a, d};
    @(posedge i_clk);
    req <= '0;
    #1;
    ak = ack;
    rd = rdata;
  endtask
  task automatic step(input logic [11:0] e);
    @(posedge i_clk);
    ev <= e;
    @(posedge i_clk);
    ev <= '0;
    #1;
  endtask
  task automatic rst(input logic [15:0] f, input logic [1:0] c, input logic [15:0] e);
    @(posedge i_clk);
    i_rstn <= 1'b0;
    flip <= f;
    cause <= c;
    repeat (2) @(posedge i_clk);
    #1 chk("reset", status, 16'h0000);
    @(posedge i_clk);
    i_rstn <= 1'b1;
    @(posedge i_clk);
    #1 chk("init", status, e);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    rst(16'hFFFF, 2'b11, 16'hF207);
    acc(1'b1, 7'h25, 16'hFFFF);
    chk("w1", status, 16'hF207);
    acc(1'b0, 7'h25, 16'h0000);
    chk("rd", rd, 16'hF207);
    acc(1'b1, 7'h26, 16'h0000);
    chk("unmapped", {status[15:1], ak}, 16'hF206);
    acc(1'b1, 7'h25, 16'h0000);
    chk("w0c", {status[15:1], ak}, 16'h0001);
    $display("test registers done");
    for (int i = 0; i < 12; i++) begin
      step(12'h800 >> i);
      chk("event", status, 16'h0001 << pos[i]);
      @(posedge i_clk);
      #1 chk("new_flag", nf, 16'h0001 << pos[i]);
      acc(1'b1, 7'h25, ~(16'h0001 << pos[i]));
      chk("clear", status, 16'h0000);
    end
    $display("test events done");
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clk);
      det <= fs2_pkg::fs2_detail_t'(42'h1 << dpos[k]);
      repeat (2) @(posedge i_clk);
      acc(1'b1, 7'h25, 16'h0000);
      chk("summary", status, 16'h0040 >> k);
      @(posedge i_clk);
      det <= '0;
      repeat (2) @(posedge i_clk);
      #1 chk("summary_off", status, 16'h0000);
    end
    $display("test summaries done");
    step(12'h004);
    rst(16'h0000, 2'b10, 16'h0004);
    rst(16'h0000, 2'b00, 16'h0000);
    $display("test resets done");
    end_sim;
  end
  initial begin
    repeat (5000) @(posedge i_clk);
    err_count++;
    end_sim;
  end
endmodule // fs2_fault_status_tb
`default_nettype wire
